// ==== hdl/dcc_regs.sv ====
/*
 * Device capabilities and device control/status register pair of one
 * switch port, reached through the port's configuration access port.
 * Assumes one access per request pulse; answer comes one cycle later.
 */
// Behaviour
// R1: supported payload resets to 001b with strap low, 010b with strap high.
// R2: each port advertises up to 512-byte payload in the 3-bit field; a default load can set any 3-bit value, up to 111b.
// R3: supported payload default overridable by strap, SMBus or EEPROM load.
// R4: phantom functions supported field always reads 00b.
// R5: extended tag supported bit always reads zero.
// R6: L0s and L1 acceptable latency fields are read-only, reset 000b.
// R7: role-based error bit resets to one, overridable by default loads.
// R8: upstream slot power value resets 00h, captured from slot power message.
// R9: upstream slot power scale resets 00b, captured from slot power message.
// R10: control bits 0..3 are error reporting enables, reset disabled.
// R11: relaxed ordering enable is read-only zero.
// R12: no-snoop enable is read-only zero.
// R13: programmed max payload is read-write, resets 000b, sets port payload.
// R14: writes above supported payload store the supported value instead.
// R15: extended tag and phantom enables read zero, reset zero.
// R16: aux power enable is sticky read-write, reset zero, permits aux power.
// R17: max read request size is hardwired 000b.
// R18: error detected flags set regardless of reporting enables.
// R19: writes to read-only or reserved bits ignored; reserved reads zero.
// R20: aux power enable survives port reset, clears only on power-on reset.
`timescale 1ns/10ps
module dcc_regs #(
    parameter bit IS_UPSTREAM = 1'b1
) (
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    // configuration access
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [dcc_pkg::DCC_ADDR_W-1:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // strap and default loader
    input wire logic payload_size_strap,
    input wire logic dflt_load,
    input wire logic [2:0] dflt_mps_sup,
    input wire logic dflt_role_err,
    // slot power message
    input wire logic spl_msg_valid,
    input wire logic [7:0] spl_msg_value,
    input wire logic [1:0] spl_msg_scale,
    // errors and power
    input wire logic [3:0] err_event,
    input wire logic aux_power_present,
    output logic [3:0] err_detected,
    output logic [3:0] err_report,
    // controls to the port
    output logic [3:0] err_report_en,
    output logic [2:0] max_payload,
    output logic aux_pm_en
);
    import dcc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [3:0] err_en;
        logic [2:0] mps;
        logic aux_pm;
    } dcc_regs_st_t;

    dcc_regs_st_t st_reg;
    dcc_regs_st_t st_next;

    logic [2:0] mps_sup;
    logic role_err;
    logic [7:0] spl_value;
    logic [1:0] spl_scale;
    logic [3:0] clr_mask;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic ctl_wr;

    function automatic logic dcc_hit(input logic [DCC_ADDR_W-1:0] a,
                                     input logic [7:0] ofs);
        dcc_hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------
    dcc_cap_src #(
        .IS_UPSTREAM(IS_UPSTREAM)
    ) u_cap (
        .clk(clk),
        .reset(reset),
        .payload_size_strap(payload_size_strap),
        .dflt_load(dflt_load),
        .dflt_mps_sup(dflt_mps_sup),
        .dflt_role_err(dflt_role_err),
        .spl_msg_valid(spl_msg_valid),
        .spl_msg_value(spl_msg_value),
        .spl_msg_scale(spl_msg_scale),
        .mps_sup(mps_sup),
        .role_err(role_err),
        .spl_value(spl_value),
        .spl_scale(spl_scale)
    );

    dcc_err_stat u_err (
        .clk(clk),
        .reset(reset),
        .err_event(err_event),
        .report_en(st_reg.err_en),
        .clr_mask(clr_mask),
        .detected(err_detected),
        .report(err_report)
    );

    // ------------------------------------------------------------------
    // read words
    // ------------------------------------------------------------------
    always_comb begin
        cap_word = '0; // see R19
        cap_word[DCC_CAP_MPS_LSB +: 3] = mps_sup; // see R2
        cap_word[DCC_CAP_PHANTOM_LSB +: 2] = DCC_PHANTOM_SUP_VAL; // see R4
        cap_word[DCC_CAP_EXT_TAG_BIT] = 1'b0; // see R5
        cap_word[DCC_CAP_L0S_LAT_LSB +: 3] = DCC_LAT_RST; // see R6
        cap_word[DCC_CAP_L1_LAT_LSB +: 3] = DCC_LAT_RST; // see R6
        cap_word[DCC_CAP_ROLE_ERR_BIT] = role_err;
        cap_word[DCC_CAP_SPL_VAL_LSB +: 8] = spl_value;
        cap_word[DCC_CAP_SPL_SCL_LSB +: 2] = spl_scale;
    end

    always_comb begin
        ctl_word = '0; // see R19
        ctl_word[DCC_CTL_ERR_EN_LSB +: 4] = st_reg.err_en;
        ctl_word[DCC_CTL_RELAX_BIT] = 1'b0; // see R11
        ctl_word[DCC_CTL_MPS_LSB +: 3] = st_reg.mps;
        ctl_word[DCC_CTL_EXT_TAG_BIT] = 1'b0; // see R15
        ctl_word[DCC_CTL_PHANTOM_BIT] = 1'b0; // see R15
        ctl_word[DCC_CTL_AUX_PM_BIT] = st_reg.aux_pm;
        ctl_word[DCC_CTL_NO_SNOOP_BIT] = 1'b0; // see R12
        ctl_word[DCC_CTL_MRRS_LSB +: 3] = DCC_MRRS_VAL; // see R17
        ctl_word[DCC_STS_ERR_LSB +: 4] = err_detected;
        ctl_word[DCC_STS_AUX_DET_BIT] = aux_power_present;
    end

    assign ctl_wr = cfg_req && cfg_we && dcc_hit(cfg_addr, DCC_OFS_DEV_CTL);
    // write-one-to-clear on the status half
    assign clr_mask = (ctl_wr && cfg_be[2]) ? cfg_wdata[DCC_STS_ERR_LSB +: 4] : 4'h0;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.ack = cfg_req;
        if (cfg_req && !cfg_we) begin
            if (dcc_hit(cfg_addr, DCC_OFS_DEV_CAP)) begin
                st_next.rdata = cap_word;
            end else if (dcc_hit(cfg_addr, DCC_OFS_DEV_CTL)) begin
                st_next.rdata = ctl_word;
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end
        // capabilities word takes no writes at all
        if (ctl_wr && cfg_be[0]) begin
            st_next.err_en = cfg_wdata[DCC_CTL_ERR_EN_LSB +: 4]; // see R10
            if (cfg_wdata[DCC_CTL_MPS_LSB +: 3] > mps_sup) begin
                st_next.mps = mps_sup; // see R14
            end else begin
                st_next.mps = cfg_wdata[DCC_CTL_MPS_LSB +: 3]; // see R13
            end
        end
        if (ctl_wr && cfg_be[1]) begin
            st_next.aux_pm = cfg_wdata[DCC_CTL_AUX_PM_BIT]; // see R16
        end
        if (reset || power_on_reset) begin
            st_next.ack = 1'b0;
            st_next.rdata = 32'h0000_0000;
            st_next.err_en = DCC_ERR_EN_RST; // see R10
            st_next.mps = DCC_MPS_RST; // see R13
            // sticky bit only falls on power-on reset
            st_next.aux_pm = power_on_reset ? 1'b0 : st_reg.aux_pm; // see R20
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign cfg_ack = st_reg.ack;
    assign cfg_rdata = st_reg.rdata;
    assign err_report_en = st_reg.err_en;
    assign max_payload = st_reg.mps;
    assign aux_pm_en = st_reg.aux_pm;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking dcc_cb @(posedge clk);
    endclocking
    default disable iff (reset || power_on_reset);

    a_ack_one_cycle: assert property ( // answer comes one cycle after each request
        cfg_req |=> cfg_ack ##1 (cfg_ack == $past(cfg_req)))
        else $error("configuration answer not one cycle after request");

    a_mps_sup_strap: assert property ( // see R1
        $fell(reset) && !power_on_reset && !$past(dflt_load) |->
            mps_sup == ($past(payload_size_strap) ? 3'h2 : 3'h1))
        else $error("supported payload does not follow strap at reset");

    a_cap_ro_fields: assert property ( // see R4
        cfg_req && !cfg_we && cfg_addr == DCC_OFS_DEV_CAP |=>
            cfg_rdata[4:3] == 2'b00 && cfg_rdata[17:16] == 2'b00)
        else $error("phantom or reserved capability bits nonzero");

    a_cap_ext_tag: assert property ( // see R5
        cfg_req && !cfg_we && cfg_addr == DCC_OFS_DEV_CAP |=> !cfg_rdata[5])
        else $error("extended tag supported reads one");

    a_cap_latency: assert property ( // see R6
        cfg_req && !cfg_we && cfg_addr == DCC_OFS_DEV_CAP |=>
            cfg_rdata[11:6] == 6'h00 && cfg_rdata[14:12] == 3'h0)
        else $error("acceptable latency fields nonzero");

    a_ctl_ro_zero: assert property ( // see R11
        cfg_req && !cfg_we && cfg_addr == DCC_OFS_DEV_CTL |=>
            !cfg_rdata[4] && !cfg_rdata[8] && !cfg_rdata[9] && !cfg_rdata[11]
            && cfg_rdata[15:12] == 4'h0)
        else $error("hardwired control bits read nonzero");

    a_mps_clamp: assert property ( // see R14
        ctl_wr && cfg_be[0] && cfg_wdata[7:5] > mps_sup |=> max_payload == $past(mps_sup))
        else $error("oversized payload write not clamped");

    a_mps_store: assert property ( // see R13
        ctl_wr && cfg_be[0] && cfg_wdata[7:5] <= mps_sup |=>
            max_payload == $past(cfg_wdata[7:5]) && err_report_en == $past(cfg_wdata[3:0]))
        else $error("control write not stored");

    a_aux_sticky: assert property (disable iff (power_on_reset) // see R20
        reset |=> aux_pm_en == $past(aux_pm_en))
        else $error("aux power enable lost on port reset");

    a_aux_por: assert property (disable iff (1'b0) // see R16
        power_on_reset |=> !aux_pm_en && max_payload == 3'h0 && err_report_en == 4'h0)
        else $error("power-on reset did not clear control");

    a_err_detect: assert property ( // see R18
        err_event[2] |=> err_detected[2] ##1 (err_detected[2] || $past(clr_mask[2])))
        else $error("error event not logged");

    a_spl_capture: assert property ( // see R8
        IS_UPSTREAM && spl_msg_valid |=>
            spl_value == $past(spl_msg_value) && spl_scale == $past(spl_msg_scale))
        else $error("slot power limit not captured");

    c_clamp_write: cover property (ctl_wr && cfg_be[0] && cfg_wdata[7:5] > mps_sup);
    c_spl_message: cover property (spl_msg_valid ##1 cfg_req && !cfg_we);
    c_err_reported: cover property (err_event[0] && err_report_en[0] ##1 err_report[0]);
    c_aux_kept: cover property (disable iff (power_on_reset)
        aux_pm_en ##1 reset ##1 aux_pm_en);

endmodule

// ==== hdl/dcc_pkg.sv ====
/*
 * Constants for the device capabilities and device control registers.
 * Assumes byte addresses on an 8-bit configuration offset.
 */
package dcc_pkg;

    // ------------------------------------------------------------------
    // access port
    // ------------------------------------------------------------------
    localparam int DCC_ADDR_W = 8;
    localparam logic [7:0] DCC_OFS_DEV_CAP = 8'hc4;
    localparam logic [7:0] DCC_OFS_DEV_CTL = 8'hc8;

    // ------------------------------------------------------------------
    // capabilities word fields
    // ------------------------------------------------------------------
    localparam int DCC_CAP_MPS_LSB = 0;
    localparam int DCC_CAP_PHANTOM_LSB = 3;
    localparam int DCC_CAP_EXT_TAG_BIT = 5;
    localparam int DCC_CAP_L0S_LAT_LSB = 6;
    localparam int DCC_CAP_L1_LAT_LSB = 9;
    localparam int DCC_CAP_ROLE_ERR_BIT = 15;
    localparam int DCC_CAP_SPL_VAL_LSB = 18;
    localparam int DCC_CAP_SPL_SCL_LSB = 26;

    // ------------------------------------------------------------------
    // control and status word fields
    // ------------------------------------------------------------------
    localparam int DCC_CTL_ERR_EN_LSB = 0;
    localparam int DCC_CTL_RELAX_BIT = 4;
    localparam int DCC_CTL_MPS_LSB = 5;
    localparam int DCC_CTL_EXT_TAG_BIT = 8;
    localparam int DCC_CTL_PHANTOM_BIT = 9;
    localparam int DCC_CTL_AUX_PM_BIT = 10;
    localparam int DCC_CTL_NO_SNOOP_BIT = 11;
    localparam int DCC_CTL_MRRS_LSB = 12;
    localparam int DCC_STS_ERR_LSB = 16;
    localparam int DCC_STS_AUX_DET_BIT = 20;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] DCC_MPS_SUP_STRAP_LO = 3'h1;
    localparam logic [2:0] DCC_MPS_SUP_STRAP_HI = 3'h2;
    localparam logic [1:0] DCC_PHANTOM_SUP_VAL = 2'h0;
    localparam logic [2:0] DCC_LAT_RST = 3'h0;
    localparam logic DCC_ROLE_ERR_RST = 1'b1;
    localparam logic [7:0] DCC_SPL_VAL_RST = 8'h00;
    localparam logic [1:0] DCC_SPL_SCL_RST = 2'h0;
    localparam logic [3:0] DCC_ERR_EN_RST = 4'h0;
    localparam logic [2:0] DCC_MPS_RST = 3'h0;
    localparam logic [2:0] DCC_MRRS_VAL = 3'h0;

endpackage

// ==== hdl/dcc_cap_src.sv ====
/*
 * Source of the loadable capability fields: supported payload size,
 * role-based error bit and captured slot power limit.
 * Assumes default loads and slot power messages arrive as one-cycle pulses.
 */
`timescale 1ns/10ps
module dcc_cap_src #(
    parameter bit IS_UPSTREAM = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // strap and default loader
    input wire logic payload_size_strap,
    input wire logic dflt_load,
    input wire logic [2:0] dflt_mps_sup,
    input wire logic dflt_role_err,
    // slot power message
    input wire logic spl_msg_valid,
    input wire logic [7:0] spl_msg_value,
    input wire logic [1:0] spl_msg_scale,
    // fields
    output logic [2:0] mps_sup,
    output logic role_err,
    output logic [7:0] spl_value,
    output logic [1:0] spl_scale
);
    import dcc_pkg::*;

    typedef struct packed {
        logic [2:0] mps_sup;
        logic role_err;
        logic [7:0] spl_value;
        logic [1:0] spl_scale;
    } dcc_cap_st_t;

    dcc_cap_st_t st_reg;
    dcc_cap_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (reset) begin
            // strap level taken while reset is held
            st_next.mps_sup = payload_size_strap ? DCC_MPS_SUP_STRAP_HI
                                                 : DCC_MPS_SUP_STRAP_LO; // see R1 R2
            st_next.role_err = DCC_ROLE_ERR_RST; // see R7
            st_next.spl_value = DCC_SPL_VAL_RST; // see R8
            st_next.spl_scale = DCC_SPL_SCL_RST; // see R9
        end else begin
            if (dflt_load) begin
                st_next.mps_sup = dflt_mps_sup; // see R3
                st_next.role_err = dflt_role_err; // see R7
            end
            if (IS_UPSTREAM && spl_msg_valid) begin
                st_next.spl_value = spl_msg_value; // see R8
                st_next.spl_scale = spl_msg_scale; // see R9
            end
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign mps_sup = st_reg.mps_sup;
    assign role_err = st_reg.role_err;
    assign spl_value = st_reg.spl_value;
    assign spl_scale = st_reg.spl_scale;

endmodule

// ==== hdl/dcc_err_stat.sv ====
/*
 * Error detected flags and gated error report pulses.
 * Assumes error events are one-cycle pulses from the port's error logic.
 */
`timescale 1ns/10ps
module dcc_err_stat (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // events and controls
    input wire logic [3:0] err_event,
    input wire logic [3:0] report_en,
    input wire logic [3:0] clr_mask,
    // results
    output logic [3:0] detected,
    output logic [3:0] report
);
    typedef struct packed {
        logic [3:0] detected;
        logic [3:0] report;
    } dcc_err_st_t;

    dcc_err_st_t st_reg;
    dcc_err_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (reset) begin
            st_next = '0;
        end else begin
            // set beats clear in the same cycle
            st_next.detected = (st_reg.detected & ~clr_mask) | err_event; // see R18
            st_next.report = err_event & report_en; // see R10
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign detected = st_reg.detected;
    assign report = st_reg.report;

endmodule

// ==== verif/dcc_host_model.sv ====
/*
 * Host model: configuration software issuing one access per request pulse.
 * Assumes the register block answers with cfg_ack one cycle after the request.
 */
`timescale 1ns/10ps
module dcc_host_model (
    // clock
    input wire logic clk,
    // configuration access
    output logic cfg_req,
    output logic cfg_we,
    output logic [dcc_pkg::DCC_ADDR_W-1:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    import dcc_pkg::*;

    initial begin
        cfg_req = 1'h0;
        cfg_we = 1'h0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end

    task automatic access(input logic we, input logic [DCC_ADDR_W-1:0] addr,
        input logic [3:0] be, input logic [31:0] wdata, output logic [31:0] rdata,
        output logic acked);
        @(negedge clk);
        cfg_req = 1'h1;
        cfg_we = we;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = wdata;
        @(negedge clk);
        acked = cfg_ack;
        rdata = cfg_rdata;
        cfg_req = 1'h0;
        // released lines carry the inverse, never a stale copy
        cfg_we = ~cfg_we;
        cfg_addr = ~cfg_addr;
        cfg_be = ~cfg_be;
        cfg_wdata = ~cfg_wdata;
    endtask
endmodule

// ==== verif/testbench.sv ====
/*
 * Self-checking bench for the device capabilities and control registers.
 * Assumes the host model drives the access port; bench drives all else.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module testbench;
    import dcc_pkg::*;
    logic clk, reset, power_on_reset, cfg_req, cfg_we, cfg_ack;
    logic [DCC_ADDR_W-1:0] cfg_addr;
    logic [3:0] cfg_be, err_event, err_detected, err_report, err_report_en;
    logic [31:0] cfg_wdata, cfg_rdata, r;
    logic payload_size_strap, dflt_load, dflt_role_err, spl_msg_valid, aux_power_present;
    logic [2:0] dflt_mps_sup, max_payload;
    logic [7:0] spl_msg_value;
    logic [1:0] spl_msg_scale;
    logic aux_pm_en;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    dcc_regs #(.IS_UPSTREAM(1'h1)) uut (.clk(clk), .reset(reset),
        .power_on_reset(power_on_reset), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .payload_size_strap(payload_size_strap),
        .dflt_load(dflt_load), .dflt_mps_sup(dflt_mps_sup), .dflt_role_err(dflt_role_err),
        .spl_msg_valid(spl_msg_valid), .spl_msg_value(spl_msg_value),
        .spl_msg_scale(spl_msg_scale), .err_event(err_event),
        .aux_power_present(aux_power_present), .err_detected(err_detected),
        .err_report(err_report), .err_report_en(err_report_en),
        .max_payload(max_payload), .aux_pm_en(aux_pm_en));

    dcc_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    // ------------------------------------------------------------------
    // clock, watchdog, verdict
    // ------------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic do_reset(input logic por, input logic strap);
        @(negedge clk);
        reset = 1'h1;
        power_on_reset = por;
        payload_size_strap = strap;
        repeat (16) @(negedge clk);
        reset = 1'h0;
        power_on_reset = 1'h0;
        payload_size_strap = 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic k;
        host.access(1'h0, a, 4'h0, 32'h0, r, k);
        `CHK("read ack", 1'h1, k)
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] x;
        logic k;
        host.access(1'h1, a, be, d, x, k);
        `CHK("write ack", 1'h1, k)
    endtask

    task automatic pulse_err(input logic [3:0] ev);
        @(negedge clk);
        err_event = ev;
        @(negedge clk);
        err_event = 4'h0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_vals();
        rd(8'hc4);
        `CHK("cap reset", 32'h0000_8001, r)
        rd(8'hc8);
        `CHK("ctl reset", 32'h0010_0000, r)
        `CHK("max_payload", 3'h0, max_payload)
    endtask

    task automatic t_ctl_write();
        wr(8'hc8, 4'h3, 32'hffff_ffff);
        rd(8'hc8);
        `CHK("ctl ones", 32'h0010_042f, r)
        `CHK("report_en", 4'hf, err_report_en)
        `CHK("max_payload clamp", 3'h1, max_payload)
        wr(8'hc8, 4'h1, 32'h0);
        rd(8'hc8);
        `CHK("ctl byte0", 32'h0010_0400, r)
        wr(8'hc8, 4'h3, 32'h0000_0020);
        `CHK("max_payload equal", 3'h1, max_payload)
        `CHK("aux off", 1'h0, aux_pm_en)
    endtask

    task automatic t_cap_ro();
        wr(8'hc4, 4'hf, 32'hffff_ffff);
        rd(8'hc4);
        `CHK("cap after write", 32'h0000_8001, r)
        wr(8'hd0, 4'hf, 32'hffff_ffff);
        rd(8'hd0);
        `CHK("unmapped", 32'h0, r)
        @(negedge clk);
        aux_power_present = 1'h0;
        rd(8'hc8);
        `CHK("aux absent", 32'h0000_0020, r)
        aux_power_present = 1'h1;
    endtask

    task automatic t_err();
        pulse_err(4'h5);
        `CHK("report gated", 4'h0, err_report)
        `CHK("detected", 4'h5, err_detected)
        wr(8'hc8, 4'h1, 32'h0000_000f);
        pulse_err(4'ha);
        `CHK("report on", 4'ha, err_report)
        @(negedge clk);
        `CHK("report pulse", 4'h0, err_report)
        rd(8'hc8);
        `CHK("status", 32'h001f_000f, r)
        wr(8'hc8, 4'h4, 32'h0005_0000);
        rd(8'hc8);
        `CHK("w1c", 32'h001a_000f, r)
    endtask

    task automatic t_sticky();
        wr(8'hc8, 4'h3, 32'h0000_0400);
        do_reset(1'h0, 1'h0);
        `CHK("aux kept", 1'h1, aux_pm_en)
        rd(8'hc8);
        `CHK("ctl after reset", 32'h0010_0400, r)
        do_reset(1'h1, 1'h0);
        `CHK("aux por", 1'h0, aux_pm_en)
    endtask

    task automatic t_strap_dflt_spl();
        do_reset(1'h0, 1'h1);
        rd(8'hc4);
        `CHK("cap strap hi", 32'h0000_8002, r)
        wr(8'hc8, 4'h1, 32'h0000_0060);
        `CHK("clamp to 2", 3'h2, max_payload)
        @(negedge clk);
        dflt_load = 1'h1;
        dflt_mps_sup = 3'h3;
        dflt_role_err = 1'h0;
        @(negedge clk);
        dflt_load = 1'h0;
        rd(8'hc4);
        `CHK("cap loaded", 32'h0000_0003, r)
        wr(8'hc8, 4'h1, 32'h0000_0060);
        `CHK("payload 3", 3'h3, max_payload)
        @(negedge clk);
        spl_msg_valid = 1'h1;
        spl_msg_value = 8'ha5;
        spl_msg_scale = 2'h2;
        @(negedge clk);
        spl_msg_valid = 1'h0;
        rd(8'hc4);
        `CHK("slot power", 32'h0a94_0003, r)
        do_reset(1'h0, 1'h0);
        rd(8'hc4);
        `CHK("cap re-reset", 32'h0000_8001, r)
    endtask

    initial begin
        reset = 1'h1;
        power_on_reset = 1'h1;
        payload_size_strap = 1'h0;
        dflt_load = 1'h0;
        dflt_mps_sup = 3'h0;
        dflt_role_err = 1'h0;
        spl_msg_valid = 1'h0;
        spl_msg_value = 8'h00;
        spl_msg_scale = 2'h0;
        err_event = 4'h0;
        aux_power_present = 1'h1;
        do_reset(1'h1, 1'h0);
        t_reset_vals();
        t_ctl_write();
        t_cap_ro();
        t_err();
        t_sticky();
        t_strap_dflt_spl();
        close_out();
    end
endmodule
